// ### hdl/smb_pkg.sv
// Shared constants and carrier types for the segment MMU bus signalling block.
// Assumes a single system clock domain and that every pin input except the data bus is synchronised before use.
package smb_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int SMB_ADDR_W = 16;
  localparam int SMB_FC_W = 4;
  localparam int SMB_ASN_W = 8;
  localparam int SMB_SPACES = 16;
  localparam int SMB_VEC_W = 8;
  localparam int SMB_PIN_W = 34;

  // ---------------------------------------------------------------------------
  // Timing, in system clock cycles at 50 MHz
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SMB_FAULT_MIN_CYC = 3'h5;
  localparam logic [1:0] SMB_DLY_ASYNC = 2'h0;
  localparam logic [1:0] SMB_DLY_SYNC_ONE = 2'h1;
  localparam logic [1:0] SMB_DLY_SYNC_TWO = 2'h2;
  localparam logic [1:0] SMB_PEER_WAIT_CYC = 2'h2;

  // ---------------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------------
  localparam logic [SMB_ASN_W-1:0] SMB_ASN_RST = 8'h00;
  localparam logic [SMB_ADDR_W-1:0] SMB_PAD_RST = 16'h0000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SMB_MODE_ASYNC,
    SMB_MODE_SYNC_ONE,
    SMB_MODE_SYNC_TWO
  } smb_mode_t;

  typedef enum logic [2:0] {
    SMB_ST_IDLE,
    SMB_ST_XLATE,
    SMB_ST_PEER,
    SMB_ST_MAPPED,
    SMB_ST_RELEASE,
    SMB_ST_DONE
  } smb_state_t;

  // One tristate or open-drain output: level and enable.
  typedef struct packed {
    logic out;
    logic oe;
  } smb_tri_t;

  // Synchronised pin inputs; active-low pins keep their pin level.
  typedef struct packed {
    logic cs_n;
    logic iack_n;
    logic as_n;
    logic uds_n;
    logic lds_n;
    logic rw;
    logic irq_n;
    logic fault_n;
    logic mapped_strobe_n;
    logic go_n;
    logic any_n;
    logic all;
    logic mode_hi;
    logic mode_lo;
    logic [SMB_FC_W-1:0] cycle_type_code;
    logic [SMB_ADDR_W-1:0] log_addr;
  } smb_pins_t;

  // Result offered by the descriptor matcher for the current cycle.
  typedef struct packed {
    logic hit;
    logic write_protect;
    logic irq_ctl;
    logic [SMB_ADDR_W-1:0] phys_addr;
  } smb_match_t;

endpackage

// ### hdl/smb_sync2.sv
// Two-stage synchroniser for a bundle of asynchronous pin inputs.
// Assumes the caller reads only the second stage.
`timescale 1ns/10ps
module smb_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // Both stages reset to all ones, the inactive level of every active-low pin.
  // Only the second stage is visible so metastability never reaches logic.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_r <= '1;
      q <= '1;
    end else if (clk_en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // smb_sync2

// ### hdl/smb_bus_signalling.sv
// Bus-side signalling of a segment MMU: translation strobes, fault, interrupt, global lines.
// Assumes descriptor matching, register map and operation decode sit in neighbouring logic.
`timescale 1ns/10ps
module smb_bus_signalling
  import smb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic iack_n,
  input wire logic as_n,
  input wire logic uds_n,
  input wire logic lds_n,
  input wire logic rw,
  input wire logic [SMB_FC_W-1:0] cycle_type_code,
  input wire logic [SMB_ADDR_W-1:0] log_addr,
  input wire logic mode_hi,
  input wire logic mode_lo,
  input wire logic irq_n_in,
  output logic irq_n_out,
  output logic irq_n_oe,
  input wire logic fault_n_in,
  output logic fault_n_out,
  output logic fault_n_oe,
  input wire logic mapped_strobe_n_in,
  output logic mapped_strobe_n_out,
  output logic mapped_strobe_n_oe,
  input wire logic go_n_in,
  output logic go_n_out,
  output logic go_n_oe,
  input wire logic any_n_in,
  output logic any_n_out,
  output logic any_n_oe,
  input wire logic all_in,
  output logic all_out,
  output logic all_oe,
  output logic transceiver_enable_n_out,
  output logic transceiver_enable_n_oe,
  output logic phys_addr_latch_hold_n_out,
  output logic phys_addr_latch_hold_n_oe,
  output logic protect_write_block_n_out,
  output logic protect_write_block_n_oe,
  input wire logic [SMB_ADDR_W-1:0] phys_addr_data_bus_in,
  output logic [SMB_ADDR_W-1:0] phys_addr_data_bus_out,
  output logic phys_addr_data_bus_oe,
  output logic [SMB_ASN_W-1:0] cycle_asn,
  output logic [SMB_ADDR_W-1:0] match_log_addr,
  input wire smb_match_t match,
  input wire logic space_wr,
  input wire logic [SMB_FC_W-1:0] space_wr_idx,
  input wire logic [SMB_ASN_W-1:0] space_wr_data,
  input wire logic global_irq_gate,
  input wire logic pending_any,
  input wire logic [SMB_VEC_W-1:0] vector_register,
  input wire logic op_is_global,
  input wire logic local_any_event,
  input wire logic local_all_event,
  output logic pending_flag_set,
  output logic fault_seen,
  output logic peer_mapped_seen,
  output logic global_master,
  output logic global_slave,
  output logic any_seen,
  output logic all_seen,
  output logic iack_active,
  output logic [SMB_ADDR_W-1:0] reg_wdata,
  output logic [1:0] mode_code
);

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------
  smb_pins_t pins_raw;
  smb_pins_t pins;
  logic [SMB_PIN_W-1:0] pins_q;

  // All pin inputs except phys_addr_data_bus_in pass two flops; the bundle resets to inactive pin levels.
  assign pins_raw = '{cs_n: cs_n, iack_n: iack_n, as_n: as_n, uds_n: uds_n, lds_n: lds_n,
                      rw: rw, irq_n: irq_n_in, fault_n: fault_n_in,
                      mapped_strobe_n: mapped_strobe_n_in, go_n: go_n_in, any_n: any_n_in,
                      all: all_in, mode_hi: mode_hi, mode_lo: mode_lo,
                      cycle_type_code: cycle_type_code, log_addr: log_addr};

  smb_sync2 #(
    .WIDTH(SMB_PIN_W)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .d(pins_raw),
    .q(pins_q)
  );

  assign pins = smb_pins_t'(pins_q);

  // ---------------------------------------------------------------------------
  // Decoded conditions
  // ---------------------------------------------------------------------------
  logic cs_act;
  logic iack_req;
  logic as_act;
  logic write_cycle;
  smb_mode_t mode;
  logic [1:0] mode_dly;

  assign cs_act = ~pins.cs_n;
  assign as_act = ~pins.as_n;
  assign write_cycle = ~pins.rw;
  // Acknowledge needs the sensed request line, acknowledge and a data strobe together.
  assign iack_req = ~pins.irq_n & ~pins.iack_n & (~pins.uds_n | ~pins.lds_n);

  // An open mode pin is seen as neither level; the pad buffer reports hi and lo separately.
  always_comb begin
    if (pins.mode_hi & ~pins.mode_lo) begin
      mode = SMB_MODE_SYNC_ONE;
      mode_dly = SMB_DLY_SYNC_ONE;
    end else if (pins.mode_lo & ~pins.mode_hi) begin
      mode = SMB_MODE_SYNC_TWO;
      mode_dly = SMB_DLY_SYNC_TWO;
    end else begin
      mode = SMB_MODE_ASYNC;
      mode_dly = SMB_DLY_ASYNC;
    end
  end

  assign mode_code = mode;

  // ---------------------------------------------------------------------------
  // Space table
  // ---------------------------------------------------------------------------
  logic [SMB_ASN_W-1:0] space_table [SMB_SPACES];

  // Table writes come from the operation decoder on the same clock.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SMB_SPACES; i++) begin
        space_table[i] <= SMB_ASN_RST;
      end
    end else if (clk_en && space_wr) begin
      space_table[space_wr_idx] <= space_wr_data;
    end
  end

  // The cycle type code selects this cycle's address space number.
  assign cycle_asn = space_table[pins.cycle_type_code];
  // All logical address bits reach the matcher unchanged after the synchroniser.
  assign match_log_addr = pins.log_addr;

  // ---------------------------------------------------------------------------
  // Translation sequencer
  // ---------------------------------------------------------------------------
  smb_state_t state_r;
  smb_state_t state_nxt;
  logic [1:0] dly_r;
  logic [SMB_ADDR_W-1:0] phys_r;
  logic wp_hit_r;
  logic fault_det;
  logic translate_ok;

  // A fresh cycle starts on the address strobe when the unit is not itself addressed.
  always_comb begin
    state_nxt = state_r;
    fault_det = 1'b0;
    translate_ok = 1'b0;
    case (state_r)
      SMB_ST_IDLE: begin
        if (as_act && !cs_act && pins.iack_n) begin
          state_nxt = SMB_ST_XLATE;
        end
      end
      SMB_ST_XLATE: begin
        if (!as_act) begin
          state_nxt = SMB_ST_IDLE;
        end else if (dly_r == 2'h0) begin
          if (!match.hit) begin
            state_nxt = SMB_ST_PEER;
          end else if (match.write_protect && write_cycle) begin
            fault_det = 1'b1;
            state_nxt = SMB_ST_DONE;
          end else begin
            translate_ok = 1'b1;
            state_nxt = SMB_ST_MAPPED;
          end
        end
      end
      SMB_ST_PEER: begin
        // A miss here is an undefined segment only if no peer maps the cycle.
        if (!pins.mapped_strobe_n) begin
          state_nxt = SMB_ST_DONE;
        end else if (dly_r == 2'h0) begin
          fault_det = 1'b1;
          state_nxt = SMB_ST_DONE;
        end
      end
      SMB_ST_MAPPED: begin
        if (!as_act) begin
          state_nxt = SMB_ST_RELEASE;
        end
      end
      SMB_ST_RELEASE: begin
        state_nxt = SMB_ST_IDLE;
      end
      SMB_ST_DONE: begin
        if (!as_act) begin
          state_nxt = SMB_ST_IDLE;
        end
      end
      default: begin
        state_nxt = SMB_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= SMB_ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // The strobe delay follows the mode; the peer wait reuses the same counter.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dly_r <= 2'h0;
    end else if (clk_en) begin
      if (state_r == SMB_ST_IDLE) begin
        dly_r <= mode_dly;
      end else if (state_r == SMB_ST_XLATE && state_nxt == SMB_ST_PEER) begin
        dly_r <= SMB_PEER_WAIT_CYC;
      end else if (dly_r != 2'h0) begin
        dly_r <= dly_r - 2'h1;
      end
    end
  end

  // Physical address and protect flag are frozen for the whole mapped phase.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phys_r <= SMB_PAD_RST;
      wp_hit_r <= 1'b0;
    end else if (clk_en && translate_ok) begin
      phys_r <= match.phys_addr;
      wp_hit_r <= match.write_protect;
    end
  end

  // The matched segment's pending flag is set in the same cycle as the strobe.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pending_flag_set <= 1'b0;
    end else if (clk_en) begin
      pending_flag_set <= translate_ok & match.irq_ctl;
    end
  end

  // ---------------------------------------------------------------------------
  // Fault timing
  // ---------------------------------------------------------------------------
  logic [2:0] fault_cnt_r;
  logic fault_hold_r;

  // Counting begins at the detecting edge; the strobe hold covers long cycles.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_cnt_r <= 3'h0;
      fault_hold_r <= 1'b0;
    end else if (clk_en) begin
      if (fault_det) begin
        fault_cnt_r <= SMB_FAULT_MIN_CYC;
        fault_hold_r <= 1'b1;
      end else begin
        if (fault_cnt_r != 3'h0) begin
          fault_cnt_r <= fault_cnt_r - 3'h1;
        end
        if (!as_act) begin
          fault_hold_r <= 1'b0;
        end
      end
    end
  end

  // Drive low while either the minimum count or the strobe still holds.
  assign fault_n_out = 1'b0;
  assign fault_n_oe = (fault_cnt_r != 3'h0) | (fault_hold_r & as_act);
  // The sensed line covers faults from every unit; status logic records it.
  assign fault_seen = ~pins.fault_n;
  logic [1:0] own_strobe_r;

  // Our own strobe returns through the synchroniser two cycles late; mask that echo.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      own_strobe_r <= 2'h0;
    end else if (clk_en) begin
      own_strobe_r <= {own_strobe_r[0], (state_r == SMB_ST_MAPPED)};
    end
  end

  assign peer_mapped_seen = ~pins.mapped_strobe_n & (state_r != SMB_ST_MAPPED)
                            & ~(|own_strobe_r);

  // ---------------------------------------------------------------------------
  // Strobes and address bus
  // ---------------------------------------------------------------------------
  logic mapped_drv;

  assign mapped_drv = (state_r == SMB_ST_MAPPED);

  // Strobe is driven low while mapped, then driven high for one cycle before it floats.
  assign mapped_strobe_n_out = ~mapped_drv;
  assign mapped_strobe_n_oe = mapped_drv | (state_r == SMB_ST_RELEASE);
  // Write block rides with the strobe for protected segments, reads included.
  assign protect_write_block_n_out = ~(mapped_drv & wp_hit_r);
  assign protect_write_block_n_oe = mapped_strobe_n_oe;
  // Latch hold spans the mapped phase and the release cycle, so it ends after the strobe.
  assign phys_addr_latch_hold_n_out = ~(mapped_drv | (state_r == SMB_ST_RELEASE));
  assign phys_addr_latch_hold_n_oe = mapped_drv | (state_r == SMB_ST_RELEASE)
                                     | (state_r == SMB_ST_IDLE);

  // ---------------------------------------------------------------------------
  // Interrupt and acknowledge
  // ---------------------------------------------------------------------------
  assign irq_n_out = 1'b0;
  // Request follows the pending flags and the gate; either clearing drops it.
  assign irq_n_oe = pending_any & global_irq_gate;
  assign iack_active = iack_req;

  // Bus data is registered; the vector wins over the address during acknowledge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phys_addr_data_bus_out <= SMB_PAD_RST;
      phys_addr_data_bus_oe <= 1'b0;
    end else if (clk_en) begin
      if (iack_req) begin
        phys_addr_data_bus_out <= {{(SMB_ADDR_W-SMB_VEC_W){1'b0}}, vector_register};
        phys_addr_data_bus_oe <= 1'b1;
      end else if (translate_ok || mapped_drv) begin
        phys_addr_data_bus_out <= translate_ok ? match.phys_addr : phys_r;
        phys_addr_data_bus_oe <= 1'b1;
      end else begin
        phys_addr_data_bus_oe <= 1'b0;
      end
    end
  end

  // Transceivers are enabled only for our own register or acknowledge access.
  assign transceiver_enable_n_out = ~(cs_act | iack_req);
  // Direction comes from read/write outside; floating when not selected.
  assign transceiver_enable_n_oe = cs_act | iack_req;

  // Register write data is captured on a selected write with a data strobe.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_wdata <= SMB_PAD_RST;
    end else if (clk_en && cs_act && write_cycle && (~pins.uds_n | ~pins.lds_n)) begin
      reg_wdata <= phys_addr_data_bus_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Global operation lines
  // ---------------------------------------------------------------------------
  assign global_master = cs_act & op_is_global;
  assign global_slave = ~pins.go_n & ~cs_act;
  assign go_n_out = ~global_master;
  assign go_n_oe = global_master;
  assign any_n_out = 1'b0;
  assign any_n_oe = global_slave & local_any_event;
  // Only a pull-down is ever driven, so the line is high only if all units release.
  assign all_out = 1'b0;
  assign all_oe = (global_slave | global_master) & ~local_all_event;
  assign any_seen = ~pins.any_n;
  assign all_seen = pins.all;

endmodule // smb_bus_signalling

// ### test/smb_peer.sv
// Shared-line model: pull-ups, wired-OR and wired-AND lines, plus one peer unit.
// Assumes the bench commands the peer through the peer_ inputs.
`timescale 1ns/10ps
module smb_peer (
  input wire logic irq_n_oe,
  input wire logic fault_n_oe,
  input wire logic mapped_strobe_n_out,
  input wire logic mapped_strobe_n_oe,
  input wire logic go_n_out,
  input wire logic go_n_oe,
  input wire logic any_n_oe,
  input wire logic all_oe,
  input wire logic peer_strobe,
  input wire logic peer_fault,
  input wire logic peer_go,
  input wire logic peer_all_low,
  output logic irq_n_in,
  output logic fault_n_in,
  output logic mapped_strobe_n_in,
  output logic go_n_in,
  output logic any_n_in,
  output logic all_in
);
  // Open-drain lines: the pull-up holds them high until any party pulls low.
  assign irq_n_in = !irq_n_oe;
  assign fault_n_in = !(fault_n_oe || peer_fault);
  assign any_n_in = !any_n_oe;
  assign all_in = !(all_oe || peer_all_low);
  // Three-state lines: one driver at a time, so a released line shows the pull-up.
  assign mapped_strobe_n_in = mapped_strobe_n_oe ? mapped_strobe_n_out : !peer_strobe;
  assign go_n_in = go_n_oe ? go_n_out : !peer_go;
endmodule // smb_peer

// ### test/smb_bus_signalling_sva.sv
// Concurrent checks on the pins of the bus signalling block.
// Assumes pin inputs reach the core through two-flop synchronisers.
`timescale 1ns/10ps
module smb_sva
  import smb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic iack_n,
  input wire logic pending_any,
  input wire logic global_irq_gate,
  input wire logic [SMB_VEC_W-1:0] vector_register,
  input wire logic local_any_event,
  input wire logic irq_n_oe,
  input wire logic fault_n_out,
  input wire logic fault_n_oe,
  input wire logic mapped_strobe_n_out,
  input wire logic mapped_strobe_n_oe,
  input wire logic go_n_out,
  input wire logic go_n_oe,
  input wire logic any_n_out,
  input wire logic any_n_oe,
  input wire logic transceiver_enable_n_out,
  input wire logic transceiver_enable_n_oe,
  input wire logic phys_addr_latch_hold_n_out,
  input wire logic phys_addr_latch_hold_n_oe,
  input wire logic protect_write_block_n_out,
  input wire logic protect_write_block_n_oe,
  input wire logic [SMB_ADDR_W-1:0] phys_addr_data_bus_out,
  input wire logic phys_addr_data_bus_oe,
  input wire logic global_master,
  input wire logic global_slave,
  input wire logic iack_active
);
  // ------------------------------------------------
  // Asserted levels of the three-state outputs
  // ------------------------------------------------
  wire strb = mapped_strobe_n_oe && !mapped_strobe_n_out;
  wire hold = phys_addr_latch_hold_n_oe && !phys_addr_latch_hold_n_out;
  wire wblk = protect_write_block_n_oe && !protect_write_block_n_out;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // The fault pulse starts on the detection edge and must last five cycles.
  sequence s_fault_start;
    $rose(fault_n_oe);
  endsequence
  sequence s_fault_hold;
    (fault_n_oe && !fault_n_out) [*5];
  endsequence
  sequence s_strb_end;
    $fell(strb);
  endsequence
  xcvr_select_a: assert property (
    transceiver_enable_n_oe |-> !transceiver_enable_n_out && (!$past(cs_n, 2) || !$past(iack_n, 2)))
    else $error("transceiver enable without select");
  hold_during_a: assert property (strb |-> hold)
    else $error("latch hold missing under strobe");
  hold_after_a: assert property (s_strb_end |-> hold)
    else $error("latch hold released with strobe");
  irq_link_a: assert property (irq_n_oe == (pending_any && global_irq_gate))
    else $error("interrupt request mismatch");
  vector_out_a: assert property (
    iack_active |=> phys_addr_data_bus_oe && phys_addr_data_bus_out == 16'($past(vector_register)))
    else $error("vector not on bus");
  fault_min_a: assert property (s_fault_start |-> s_fault_hold)
    else $error("fault shorter than five cycles");
  no_map_fault_a: assert property (fault_n_oe |-> !strb)
    else $error("strobe given with fault");
  master_go_a: assert property (global_master |-> go_n_oe && !go_n_out && !global_slave)
    else $error("master not driving global line");
  any_pull_a: assert property (global_slave && local_any_event |-> any_n_oe && !any_n_out)
    else $error("slave event not reported");
  wblk_with_map_a: assert property (wblk |-> strb)
    else $error("write block without strobe");
endmodule // smb_sva

bind smb_bus_signalling smb_sva u_smb_sva (.*);

// ### test/smb_bus_signalling_test.sv
// Self-checking bench for the segment MMU bus signalling block.
// Assumes the checker binds itself and smb_peer resolves the shared lines.
`timescale 1ns/10ps
module smb_bus_signalling_test
  import smb_pkg::*;
();
  logic clk_sys = 1'h0, rst = 1'h1, clk_en = 1'h1, cs_n = 1'h1, iack_n = 1'h1, as_n = 1'h1;
  logic uds_n = 1'h1, lds_n = 1'h1, rw = 1'h1, mode_hi = 1'h0, mode_lo = 1'h0, space_wr = 1'h0;
  logic global_irq_gate = 1'h0, pending_any = 1'h0, op_is_global = 1'h0;
  logic local_any_event = 1'h0, local_all_event = 1'h0, peer_strobe = 1'h0, peer_fault = 1'h0;
  logic peer_go = 1'h0, peer_all_low = 1'h0;
  logic [3:0] cycle_type_code = 4'h0, space_wr_idx = 4'h0;
  logic [7:0] space_wr_data = 8'h00, vector_register = 8'h00, cycle_asn;
  logic [15:0] log_addr = 16'h0000, cpu_data = 16'h0000;
  smb_match_t match = '0;
  logic irq_n_in, fault_n_in, mapped_strobe_n_in, go_n_in, any_n_in, all_in, irq_n_out, irq_n_oe;
  logic fault_n_out, fault_n_oe, mapped_strobe_n_out, mapped_strobe_n_oe, go_n_out, go_n_oe;
  logic any_n_out, any_n_oe, all_out, all_oe, transceiver_enable_n_out, transceiver_enable_n_oe;
  logic phys_addr_latch_hold_n_out, phys_addr_latch_hold_n_oe, protect_write_block_n_out;
  logic protect_write_block_n_oe, phys_addr_data_bus_oe, pending_flag_set, fault_seen;
  logic peer_mapped_seen, global_master, global_slave, any_seen, all_seen, iack_active;
  logic [15:0] phys_addr_data_bus_out, match_log_addr, reg_wdata;
  logic [1:0] mode_code;
  int bad_count = 0, checked = 0, cyc = 0, pf_cnt = 0;
  wire strb = mapped_strobe_n_oe && !mapped_strobe_n_out;
  // Transceiver model: enable from the block, direction from rw alone.
  wire [15:0] phys_addr_data_bus_in = (transceiver_enable_n_oe && !transceiver_enable_n_out
                                       && !rw) ? cpu_data : 16'h0000;
  // Physical strobe gating: a write is blocked while the write block is asserted.
  wire phys_ds_n = (uds_n && lds_n) || (!rw && !protect_write_block_n_out
                   && protect_write_block_n_oe);
  smb_bus_signalling u_smb_bus_signalling (.*);
  smb_peer u_smb_peer (.*);
  always #10 clk_sys = ~clk_sys;
  // Catch the one-cycle pending pulse, and cut a hang short.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (pending_flag_set === 1'h1) pf_cnt <= pf_cnt + 1;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Start a cycle; waits, bounded, for a strobe or a fault and counts cycles.
  task automatic start(input smb_match_t m, input logic r, output int n);
    match = m;
    rw = r;
    as_n = 1'h0;
    n = 0;
    while (strb !== 1'h1 && fault_n_oe !== 1'h1 && n < 20) begin
      tick(1);
      n++;
    end
  endtask
  task automatic stop();
    as_n = 1'h1;
    peer_strobe = 1'h0;
    tick(8);
  endtask
  task automatic t_modes();
    int n[3];
    smb_mode_t exp_m[3] = '{SMB_MODE_ASYNC, SMB_MODE_SYNC_ONE, SMB_MODE_SYNC_TWO};
    log_addr = 16'h5A3C;
    for (int i = 0; i < 3; i++) begin
      {mode_hi, mode_lo} = i == 1 ? 2'h2 : i == 2 ? 2'h1 : 2'h0;
      tick(4);
      chk("mode", exp_m[i], mode_code);
      start('{1'h1, 1'h0, 1'h0, 16'hC3A5}, 1'h1, n[i]);
      chk("map", 1'h1, strb);
      chk("pad", 16'hC3A5, phys_addr_data_bus_out);
      chk("log", 16'h5A3C, match_log_addr);
      chk("hold", 1'h0, phys_addr_latch_hold_n_out);
      chk("wblk", 1'h1, protect_write_block_n_out);
      stop();
    end
    chk("dly1", 16'(SMB_DLY_SYNC_ONE - SMB_DLY_ASYNC), 16'(n[1] - n[0]));
    chk("dly2", 16'(SMB_DLY_SYNC_TWO - SMB_DLY_ASYNC), 16'(n[2] - n[0]));
    {mode_hi, mode_lo} = 2'h0;
  endtask
  // Protected read maps with the write block; protected write faults instead.
  task automatic t_protect();
    int n;
    start('{1'h1, 1'h1, 1'h0, 16'h1234}, 1'h1, n);
    chk("wblk_rd", 1'h0, protect_write_block_n_out);
    rw = 1'h0;
    lds_n = 1'h0;
    tick(1);
    chk("ds_gate", 1'h1, phys_ds_n);
    lds_n = 1'h1;
    stop();
    start('{1'h1, 1'h1, 1'h0, 16'h1234}, 1'h0, n);
    chk("flt", 1'h1, fault_n_oe);
    tick(9);
    chk("flt_as", 1'h0, fault_n_in);
    chk("no_map", 1'h1, mapped_strobe_n_in);
    chk("seen", 1'h1, fault_seen);
    stop();
    chk("flt_end", 1'h1, fault_n_in);
  endtask
  // A miss answered by the peer is fine; an unanswered miss faults five cycles.
  task automatic t_undef();
    int n;
    peer_strobe = 1'h1;
    start('0, 1'h1, n);
    chk("peer", 16'h0002, {peer_mapped_seen, fault_seen});
    stop();
    start('0, 1'h1, n);
    as_n = 1'h1;
    n = 0;
    while (fault_n_oe === 1'h1 && n < 20) begin
      n++;
      tick(1);
    end
    chk("flt_min", 16'(SMB_FAULT_MIN_CYC), 16'(n));
    peer_fault = 1'h1;
    tick(4);
    chk("peer_flt", 1'h1, fault_seen);
    peer_fault = 1'h0;
    tick(4);
  endtask
  task automatic t_irq();
    int n, p;
    p = pf_cnt;
    start('{1'h1, 1'h0, 1'h1, 16'h0F0F}, 1'h1, n);
    stop();
    chk("pend", 16'h0001, 16'(pf_cnt - p));
    pending_any = 1'h1;
    global_irq_gate = 1'h1;
    tick(1);
    chk("irq", 1'h0, irq_n_in);
    global_irq_gate = 1'h0;
    tick(1);
    chk("irq_off", 1'h1, irq_n_in);
    global_irq_gate = 1'h1;
    vector_register = 8'hA7;
    iack_n = 1'h0;
    tick(5);
    chk("no_ds", 1'h0, iack_active);
    lds_n = 1'h0;
    tick(4);
    chk("iack", 1'h1, iack_active);
    chk("vec", 16'h00A7, phys_addr_data_bus_out);
    chk("xcvr", 16'h0002, {transceiver_enable_n_oe, transceiver_enable_n_out});
    iack_n = 1'h1;
    lds_n = 1'h1;
    pending_any = 1'h0;
    tick(4);
    chk("irq_clr", 1'h1, irq_n_in);
    global_irq_gate = 1'h0;
  endtask
  task automatic t_global();
    cs_n = 1'h0;
    op_is_global = 1'h1;
    rw = 1'h0;
    lds_n = 1'h0;
    cpu_data = 16'h3C5A;
    tick(4);
    chk("master", 16'h0002, {global_master, go_n_in});
    chk("xcvr_cs", 16'h0002, {transceiver_enable_n_oe, transceiver_enable_n_out});
    chk("wdata", 16'h3C5A, reg_wdata);
    rw = 1'h1;
    lds_n = 1'h1;
    cs_n = 1'h1;
    op_is_global = 1'h0;
    peer_go = 1'h1;
    tick(4);
    chk("slave", 16'h0002, {global_slave, all_in});
    local_any_event = 1'h1;
    local_all_event = 1'h1;
    tick(4);
    chk("any", 16'h0002, {any_seen, any_n_in});
    chk("all", 16'h0003, {all_seen, all_in});
    peer_all_low = 1'h1;
    tick(4);
    chk("all_peer", 16'h0000, {all_seen, all_in});
    {peer_go, peer_all_low, local_any_event, local_all_event} = 4'h0;
    tick(4);
  endtask
  task automatic t_space();
    space_wr_idx = 4'h5;
    space_wr_data = 8'h5A;
    space_wr = 1'h1;
    tick(1);
    space_wr = 1'h0;
    cycle_type_code = 4'h5;
    tick(4);
    chk("asn5", 8'h5A, cycle_asn);
    cycle_type_code = 4'h6;
    tick(4);
    chk("asn6", 8'h00, cycle_asn);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'h0;
    tick(2);
    t_space();
    t_modes();
    t_protect();
    t_undef();
    t_irq();
    t_global();
    complete_run();
  end
endmodule // smb_bus_signalling_test
